//--- rtl/scp_consts.svh
// Constants for the stream channel port: status bit positions, widths, timing.
// Assumes inclusion by bare name from the package and design files.
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

`define SCP_NUM_IN          8
`define SCP_NUM_OUT         8
`define SCP_WORD_W          32
`define SCP_SEL_W           3
`define SCP_STATUS_W        32
`define SCP_BIT_CARRY_COPY  0
`define SCP_BIT_CHAN_ERR    27
`define SCP_BIT_CARRY       29
`define SCP_DONE_CYCLES     2
`define SCP_STATUS_RESET    32'h0000_0000

`endif

//--- rtl/scp_pkg.sv
// Types shared by the stream channel port modules.
// Assumes scp_consts.svh is on the include path.
`include "scp_consts.svh"

package scp_pkg;
    typedef logic [`SCP_WORD_W-1:0]   scp_word_t;
    typedef logic [`SCP_SEL_W-1:0]    scp_sel_t;
    typedef logic [`SCP_STATUS_W-1:0] scp_status_t;

    // Operation codes presented by the pipeline
    typedef enum logic [2:0] {
        SCP_OP_GET   = 3'h0,
        SCP_OP_NGET  = 3'h1,
        SCP_OP_CGET  = 3'h2,
        SCP_OP_NCGET = 3'h3,
        SCP_OP_PUT   = 3'h4,
        SCP_OP_NPUT  = 3'h5,
        SCP_OP_CPUT  = 3'h6,
        SCP_OP_NCPUT = 3'h7
    } scp_op_t;

    typedef enum logic [2:0] {
        SCP_ST_IDLE = 3'b001,
        SCP_ST_WAIT = 3'b010,
        SCP_ST_DONE = 3'b100
    } scp_state_t;
endpackage

//--- rtl/scp_in_mux.sv
// Input channel selector: routes one of the input channels to the sequencer.
// Assumes all channel inputs are already in the clk domain.
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"

module scp_in_mux #(
    parameter int NUM = `SCP_NUM_IN
) (
    input  wire logic [NUM-1:0]                 chanExists,
    input  wire logic [NUM-1:0]                 chanCtrl,
    input  wire logic [NUM*`SCP_WORD_W-1:0]     chanData,
    input  wire scp_pkg::scp_sel_t              selectedChannel,
    output logic                                selExists,
    output logic                                selCtrl,
    output scp_pkg::scp_word_t                  selData
);
    import scp_pkg::*;

    assign selExists = chanExists[selectedChannel];
    assign selCtrl   = chanCtrl[selectedChannel];
    assign selData   = chanData[selectedChannel*`SCP_WORD_W +: `SCP_WORD_W];
endmodule

`default_nettype wire

//--- rtl/scp_out_demux.sv
// Output channel selector: picks the full flag of the chosen output channel
// and spreads a write strobe to that channel only.
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"

module scp_out_demux #(
    parameter int NUM = `SCP_NUM_OUT
) (
    input  wire logic [NUM-1:0]      chanFull,
    input  wire scp_pkg::scp_sel_t   selectedChannel,
    input  wire logic                writeReq,
    output logic                     selFull,
    output logic [NUM-1:0]           writeVec
);
    import scp_pkg::*;

    assign selFull  = chanFull[selectedChannel];
    assign writeVec = writeReq ? (NUM'(1) << selectedChannel) : '0;
endmodule

`default_nettype wire

//--- rtl/scp_port.sv
// Stream channel port: executes get/put instructions against eight input and
// eight output word channels, stalling the pipeline or reporting by carry.
// Assumes far-end channel flags are synchronous to clk.
//
// Functional notes
// - Eight input and eight output one-directional point-to-point channels.
// - Every channel carries 32-bit words.
// - Each word travels with one control/data tag bit.
// - Blocking data get stalls until word available, then two cycles.
// - Blocking data get of a control-tagged word sets status bit 27.
// - Non-blocking data get never stalls; carry bit 29 clear on success.
// - Carry is mirrored into status bit 0.
// - Non-blocking data get of a control-tagged word sets bit 27.
// - Blocking control get stalls until word present, then two cycles.
// - Control get of a data-tagged word sets bit 27.
// - Non-blocking control get never stalls; carry clear on success.
// - Blocking put stalls while full, then writes, two cycles.
// - Blocking data put drives tag low.
// - Blocking control put drives tag high.
// - Non-blocking put never stalls; carry clear if accepted, set if full.
// - Non-blocking data put drives tag low.
// - Non-blocking control put drives tag high.
`timescale 1ns/1ps
`default_nettype none
`include "scp_consts.svh"

module scp_port #(
    parameter int NUM_IN  = `SCP_NUM_IN,
    parameter int NUM_OUT = `SCP_NUM_OUT
) (
    input  wire logic                           clk,
    input  wire logic                           srst,
    // Pipeline side
    input  wire logic                           opValid,
    input  wire scp_pkg::scp_op_t               opCode,
    input  wire scp_pkg::scp_sel_t              selectedChannel,
    input  wire scp_pkg::scp_word_t             opWriteData,
    output logic                                pipeStall,
    output logic                                opDone,
    output scp_pkg::scp_word_t                  targetRegister,
    output logic                                targetWrite,
    output scp_pkg::scp_status_t                machineStatusWord,
    // Input channels
    input  wire logic [NUM_IN-1:0]              inExists,
    input  wire logic [NUM_IN-1:0]              inCtrl,
    input  wire logic [NUM_IN*`SCP_WORD_W-1:0]  inData,
    output logic [NUM_IN-1:0]                   inRead,
    // Output channels
    input  wire logic [NUM_OUT-1:0]             outFull,
    output logic [NUM_OUT*`SCP_WORD_W-1:0]      outData,
    output logic [NUM_OUT-1:0]                  outCtrl,
    output logic [NUM_OUT-1:0]                  outWrite
);
    import scp_pkg::*;

    // ------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------
    // Sequencer state and the latched instruction come first, since the
    // channel selectors below steer on the latched channel number.
    scp_state_t         state_ff;
    scp_state_t         nxt_state;
    scp_op_t            op_ff;
    scp_sel_t           opSel_ff;
    scp_word_t          opWd_ff;

    logic               selExists;
    logic               selCtrl;
    scp_word_t          selData;
    logic               selFull;
    logic               writeReq;
    logic [NUM_OUT-1:0] writeVec;

    scp_in_mux #(.NUM(NUM_IN)) u_in_mux (
        .chanExists      (inExists),
        .chanCtrl        (inCtrl),
        .chanData        (inData),
        .selectedChannel (opSel_ff),
        .selExists       (selExists),
        .selCtrl         (selCtrl),
        .selData         (selData)
    );

    scp_out_demux #(.NUM(NUM_OUT)) u_out_demux (
        .chanFull        (outFull),
        .selectedChannel (opSel_ff),
        .writeReq        (writeReq),
        .selFull         (selFull),
        .writeVec        (writeVec)
    );

    // ------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------
    wire isPut      = op_ff[2];
    wire isCtrlOp   = op_ff[1];
    wire isNonBlock = op_ff[0];
    wire isGet      = !isPut;
    wire isDataGet  = isGet && !isCtrlOp;
    wire isCtrlGet  = isGet && isCtrlOp;
    wire inIdle     = (state_ff == SCP_ST_IDLE);
    wire inWait     = (state_ff == SCP_ST_WAIT);
    wire acceptNow  = inIdle && opValid;

    // A word can be served by the selected channel this cycle
    wire chanReady  = isPut ? !selFull : selExists;
    wire serveNow   = inWait && chanReady;
    wire failNow    = inWait && !chanReady && isNonBlock;
    wire finishNow  = serveNow || failNow;
    wire serveGet   = serveNow && isGet;
    wire servePut   = serveNow && isPut;
    // Tag mismatch: data get saw control, control get saw data
    wire tagErr     = serveNow && ((isDataGet && selCtrl) || (isCtrlGet && !selCtrl));

    assign writeReq = servePut;

    // ------------------------------------------------------------
    // Sequencer: latch cycle, serve/finish cycle, done cycle
    // ------------------------------------------------------------
    // Latching the operation costs a cycle, so a ready channel gives the
    // two-cycle completion; blocking ops wait in WAIT with stall held.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SCP_ST_IDLE: begin
                if (opValid) begin
                    nxt_state = SCP_ST_WAIT;
                end
            end
            SCP_ST_WAIT: begin
                if (finishNow) begin
                    nxt_state = SCP_ST_DONE;
                end
            end
            SCP_ST_DONE: begin
                nxt_state = SCP_ST_IDLE;
            end
            default: begin
                nxt_state = SCP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= SCP_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Operation latch
    // ------------------------------------------------------------
    // opValid is only looked at in IDLE, so a request held through a busy
    // instruction is not taken until IDLE returns, where it starts a second one.
    always_ff @(posedge clk) begin
        if (srst) begin
            op_ff <= SCP_OP_GET;
        end else if (acceptNow) begin
            op_ff <= opCode;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            opSel_ff <= '0;
        end else if (acceptNow) begin
            opSel_ff <= selectedChannel;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            opWd_ff <= '0;
        end else if (acceptNow) begin
            opWd_ff <= opWriteData;
        end
    end

    // ------------------------------------------------------------
    // Pipeline handshake outputs
    // ------------------------------------------------------------
    // Stall is raised the cycle after accept, held through WAIT, and drops with done.
    logic nxt_stall;
    assign nxt_stall = (nxt_state != SCP_ST_IDLE) && (nxt_state != SCP_ST_DONE);

    always_ff @(posedge clk) begin
        if (srst) begin
            pipeStall <= 1'b0;
        end else begin
            pipeStall <= nxt_stall;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            opDone <= 1'b0;
        end else begin
            opDone <= finishNow;
        end
    end

    // Only a served get hands a word over to the register file.
    always_ff @(posedge clk) begin
        if (srst) begin
            targetWrite <= 1'b0;
        end else begin
            targetWrite <= serveGet;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            targetRegister <= '0;
        end else if (serveGet) begin
            targetRegister <= selData;
        end
    end

    // ------------------------------------------------------------
    // Input channel read strobes
    // ------------------------------------------------------------
    // Only a served get pops a word; a failed non-blocking get pops none.
    logic [NUM_IN-1:0] nxt_inRead;
    assign nxt_inRead = (serveNow && !isPut) ? (NUM_IN'(1) << opSel_ff) : '0;

    // Read strobe is registered, so the far end sees it one cycle after the
    // word was sampled; the FSM leaves WAIT the same cycle, so no double pop.
    always_ff @(posedge clk) begin
        if (srst) begin
            inRead <= '0;
        end else begin
            inRead <= nxt_inRead;
        end
    end

    // ------------------------------------------------------------
    // Output channel write path
    // ------------------------------------------------------------
    // Data and tag change only on the strobed channel; the others keep their last write.
    always_ff @(posedge clk) begin
        if (srst) begin
            outWrite <= '0;
        end else begin
            outWrite <= writeVec;
        end
    end

    // Tag follows the op code's control bit: data puts low, control puts high.
    always_ff @(posedge clk) begin
        if (srst) begin
            outData <= '0;
            outCtrl <= '0;
        end else begin
            for (int i = 0; i < NUM_OUT; i++) begin
                if (writeVec[i]) begin
                    outData[i*`SCP_WORD_W +: `SCP_WORD_W] <= opWd_ff;
                    outCtrl[i] <= isCtrlOp;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    // Only carry, its copy and the error flag are kept here; other bits of
    // the processor status live elsewhere and read as zero.
    // The error flag is sticky; only reset clears it, as there is no clear input.
    logic carry_ff;
    logic chanErr_ff;
    logic nxt_carry;
    logic nxt_chanErr;
    assign nxt_carry   = failNow ? 1'b1 : (serveNow && isNonBlock) ? 1'b0 : carry_ff;
    // Set wins: there is no clear input, only reset empties the flag.
    assign nxt_chanErr = tagErr || chanErr_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            carry_ff <= 1'b0;
        end else begin
            carry_ff <= nxt_carry;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            chanErr_ff <= 1'b0;
        end else begin
            chanErr_ff <= nxt_chanErr;
        end
    end

    always_comb begin
        machineStatusWord                      = `SCP_STATUS_RESET;
        machineStatusWord[`SCP_BIT_CARRY]      = carry_ff;
        machineStatusWord[`SCP_BIT_CARRY_COPY] = carry_ff;
        machineStatusWord[`SCP_BIT_CHAN_ERR]   = chanErr_ff;
    end
endmodule

`default_nettype wire

//--- tb/scp_port_monitor.sv
// Checker for the stream channel port, bound to scp_port.
// Assumes far-end flags are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module scp_port_monitor #(
    parameter int NUM_IN  = 8,
    parameter int NUM_OUT = 8
) (
    input wire logic                 clk,
    input wire logic                 srst,
    input wire logic                 opValid,
    input wire scp_pkg::scp_op_t     opCode,
    input wire scp_pkg::scp_sel_t    selectedChannel,
    input wire logic                 pipeStall,
    input wire logic                 opDone,
    input wire logic                 targetWrite,
    input wire scp_pkg::scp_status_t machineStatusWord,
    input wire logic [NUM_IN-1:0]    inExists,
    input wire logic [NUM_IN-1:0]    inCtrl,
    input wire logic [NUM_IN-1:0]    inRead,
    input wire logic [NUM_OUT-1:0]   outFull,
    input wire logic [NUM_OUT-1:0]   outCtrl,
    input wire logic [NUM_OUT-1:0]   outWrite
);
    import scp_pkg::*;
    // ------
    // Operation held from its accept edge
    // ------
    logic     acc;
    logic     rdy;
    scp_op_t  opQ_ff;
    scp_sel_t selQ_ff;
    assign acc = opValid && !pipeStall && !opDone;
    assign rdy = opQ_ff[2] ? !outFull[selQ_ff] : inExists[selQ_ff];
    always_ff @(posedge clk) begin
        if (acc) begin
            opQ_ff  <= opCode;
            selQ_ff <= selectedChannel;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_nonblock_two: assert property (acc && opCode[0] |=> pipeStall && !opDone ##1 opDone && !pipeStall)
        else $error("nonblocking op timing");
    a_blocked_wait: assert property (pipeStall && !opQ_ff[0] && !rdy |=> pipeStall && !opDone)
        else $error("blocked op did not stall");
    a_ready_done: assert property (pipeStall && (rdy || opQ_ff[0]) |=> opDone && !pipeStall)
        else $error("ready op not done next cycle");
    a_read_once: assert property (|inRead |-> opDone && targetWrite && inRead == (NUM_IN'(1) << selQ_ff))
        else $error("stray read strobe");
    a_write_tag: assert property (|outWrite |-> opDone && opQ_ff[2] && outWrite == (NUM_OUT'(1) << selQ_ff)
        && outCtrl[selQ_ff] == opQ_ff[1]) else $error("bad write strobe or tag");
    a_fail_quiet: assert property (opDone && opQ_ff[0] && machineStatusWord[29] |-> !inRead && !outWrite)
        else $error("failed op moved a word");
    a_carry_result: assert property (opDone && opQ_ff[0] |-> machineStatusWord[29] == !(targetWrite || |outWrite))
        else $error("carry does not match outcome");
    a_carry_mirror: assert property (machineStatusWord[0] == machineStatusWord[29])
        else $error("carry copy differs");
    a_error_cause: assert property ($rose(machineStatusWord[27]) |-> opDone && targetWrite
        && inCtrl[selQ_ff] != opQ_ff[1]) else $error("error bit without tag mismatch");
endmodule
bind scp_port scp_port_monitor #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_mon (.clk, .srst, .opValid, .opCode,
    .selectedChannel, .pipeStall, .opDone, .targetWrite, .machineStatusWord, .inExists, .inCtrl, .inRead,
    .outFull, .outCtrl, .outWrite);
`default_nettype wire

//--- tb/scp_chan_model.sv
// Far end: one-word source per input channel, full level per output channel.
// Assumes the bench loads words and sets full levels between edges.
`timescale 1ns/1ps
`default_nettype none
module scp_chan_model (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         load,
    input  wire logic         loadCtrl,
    input  wire logic [2:0]   loadCh,
    input  wire logic [31:0]  loadWord,
    input  wire logic [7:0]   fullReq,
    input  wire logic [7:0]   inRead,
    output logic [7:0]        inExists,
    output logic [7:0]        inCtrl,
    output logic [255:0]      inData,
    output logic [7:0]        outFull
);
    assign outFull = fullReq;
    always_ff @(posedge clk) begin
        if (srst) begin
            inExists <= 8'h00;
            inCtrl   <= 8'h00;
            inData   <= 256'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                // Popped word is gone: show its inverse, never a stale copy
                if (inRead[i]) begin
                    inExists[i]        <= 1'b0;
                    inData[i*32 +: 32] <= ~inData[i*32 +: 32];
                end
            end
            if (load) begin
                inExists[loadCh]        <= 1'b1;
                inCtrl[loadCh]          <= loadCtrl;
                inData[loadCh*32 +: 32] <= loadWord;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/scp_port_bench.sv
// Self-checking bench for the stream channel port against a reference model.
// Assumes a 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module scp_port_bench;
    import scp_pkg::*;
    logic         clk = 1'b0, srst = 1'b1, opValid = 1'b0, load = 1'b0, loadCtrl = 1'b0;
    scp_op_t      opCode = SCP_OP_GET;
    scp_sel_t     sel = 3'h0, loadCh = 3'h0;
    scp_word_t    wdata = 32'h0, loadWord = 32'h0, targetRegister;
    logic [7:0]   fullReq = 8'h00, inExists, inCtrl, inRead, outFull, outCtrl, outWrite;
    logic [255:0] inData, outData;
    logic         pipeStall, opDone, targetWrite;
    scp_status_t  msw;
    int           n_mismatch = 0, check_count = 0;
    bit           carry = 1'b0, err = 1'b0;
    always #5 clk = ~clk;
    scp_port dut (.clk, .srst, .opValid, .opCode, .selectedChannel(sel), .opWriteData(wdata), .pipeStall,
        .opDone, .targetRegister, .targetWrite, .machineStatusWord(msw), .inExists, .inCtrl, .inData, .inRead,
        .outFull, .outData, .outCtrl, .outWrite);
    scp_chan_model far (.clk, .srst, .load, .loadCtrl, .loadCh, .loadWord, .fullReq, .inRead, .inExists,
        .inCtrl, .inData, .outFull);
    // ------
    // Checking and closing
    // ------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Not ready: blocking ops get their channel freed at falling edge rel, nonblocking ones fail
    task automatic runOp(input scp_op_t o, input scp_sel_t ch, input bit rdy, input bit tag, input int rel);
        int n;
        int expN;
        bit ok;
        scp_word_t w;
        w = $urandom;
        ok = rdy || !o[0];
        expN = (rdy || o[0]) ? 2 : (o[2] ? rel + 1 : rel + 2);
        loadCh = ch;
        loadCtrl = tag;
        loadWord = w;
        fullReq[ch] = o[2] && !rdy;
        if (!o[2] && rdy) begin
            load = 1'b1;
            @(negedge clk);
            load = 1'b0;
        end
        opValid = 1'b1;
        opCode = o;
        sel = ch;
        wdata = w;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            opValid = 1'b0;
            load = n == rel && !rdy && !o[0] && !o[2];
            if (n == rel && !o[0]) fullReq[ch] = 1'b0;
            if (opDone !== 1'b1) chk(pipeStall, 1'b1);
            if (n > 60) begin
                n_mismatch++;
                end_of_test();
            end
        end while (opDone !== 1'b1);
        if (o[0]) carry = !ok;
        if (!o[2] && ok && tag != o[1]) err = 1'b1;
        chk(n, expN);
        chk(targetWrite, !o[2] && ok);
        chk(inRead, (!o[2] && ok) ? 8'h01 << ch : 8'h00);
        chk(outWrite, (o[2] && ok) ? 8'h01 << ch : 8'h00);
        if (!o[2] && ok) chk(targetRegister, w);
        if (o[2] && ok) chk(outData[ch*32 +: 32], w);
        if (o[2] && ok) chk(outCtrl[ch], o[1]);
        chk(msw, {2'b00, carry, 1'b0, err, 26'h0, carry});
        chk(pipeStall, 1'b0);
        fullReq = 8'h00;
        // Let the done cycle pass: a request raised in it would be ignored
        @(negedge clk);
    endtask
    initial begin
        void'($urandom(32'h94D03656));
        repeat (10) @(negedge clk);
        srst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            runOp(scp_op_t'(i), 3'($urandom), 1'b1, i[1], 0);
            runOp(scp_op_t'(i), 3'($urandom), 1'b0, i[1], 1 + i);
            // Error bit is sticky, so a reset gives each mismatch case a clean start
            srst = 1'b1;
            @(negedge clk);
            srst = 1'b0;
            carry = 1'b0;
            err = 1'b0;
            runOp(scp_op_t'(i), 3'($urandom), 1'b1, !i[1], 0);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
